// ===== charge_supervisor_cfg.svh
/*
 * Constants for the charge supervisor: timing counts, selector codes,
 * thermal fold step count.
 * Assumes a 100 MHz ref_clk; included by bare name.
 */
`ifndef CHARGE_SUPERVISOR_CFG_SVH
`define CHARGE_SUPERVISOR_CFG_SVH

`define CLK_PERIOD_NS       10
`define TICK_PERIOD_NS      1000000
`define TICK_CYCLES         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define SAFETY_HOURS        6
`define SAFETY_TICKS        (`SAFETY_HOURS * 3600 * 1000)
`define TICK_CNT_W          17
`define SAFETY_CNT_W        25
`define SEL_NORMAL          2'h0
`define SEL_HALF_CURRENT    2'h1
`define SEL_LOW_VREG        2'h2
`define SEL_SUSPEND         2'h3
`define FOLD_STEPS          4'hA
`define VREG_DROP_MV        8'h8C
`define REDUCED_VREG_MV     13'hFDC

`endif

// ===== charge_supervisor_pkg.sv
/*
 * Types shared by the charge supervisor modules.
 * Assumes nothing beyond the cfg header.
 */
package charge_supervisor_pkg;
   typedef enum logic [1:0] {
      ZONE_NORMAL = 2'b00,
      ZONE_WARM   = 2'b01,
      ZONE_COOL   = 2'b10,
      ZONE_HALT   = 2'b11
   } zone_t;

   typedef enum logic [1:0] {
      CHG_IDLE    = 2'b00,
      CHG_RUN     = 2'b01,
      CHG_DONE    = 2'b10,
      CHG_FAULT   = 2'b11
   } chg_state_t;
endpackage

// ===== timer_ctl_if.sv
/*
 * Interface between the supervisor core and its safety timer.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ns
interface timer_ctl_if;
   logic run;
   logic slow;
   logic clear;
   logic expired;
   modport core  (output run, output slow, output clear, input expired);
   modport timer (input run, input slow, input clear, output expired);
endinterface

// ===== safety_timer.sv
/*
 * Safety timer with prescaler and half-rate counting.
 * Assumes ref_clk at 100 MHz and synchronous active-high reset.
 */
`timescale 1ns/1ns
`include "charge_supervisor_cfg.svh"
module safety_timer #(
   parameter int unsigned TICK_CYCLES  = `TICK_CYCLES,
   parameter int unsigned SAFETY_TICKS = `SAFETY_TICKS
) (
   input wire logic ref_clk,
   input wire logic reset,
   timer_ctl_if.timer ctl
);
   logic [`TICK_CNT_W-1:0]   preCnt_q;
   logic                     tick_q;
   logic                     halfPhase_q;
   logic [`SAFETY_CNT_W-1:0] count_q;
   logic                     expired_q;

   always_ff @(posedge ref_clk) begin
      if (reset || ctl.clear || !ctl.run) begin
         preCnt_q <= '0;
         tick_q   <= 1'b0;
      end else if (preCnt_q == `TICK_CNT_W'(TICK_CYCLES - 1)) begin
         preCnt_q <= '0;
         tick_q   <= 1'b1;
      end else begin
         preCnt_q <= preCnt_q + 1'b1;
         tick_q   <= 1'b0;
      end
   end

   // Slowed counting advances on every second tick only.
   always_ff @(posedge ref_clk) begin
      if (reset || ctl.clear) begin
         halfPhase_q <= 1'b0;
      end else if (tick_q && ctl.run && ctl.slow) begin
         halfPhase_q <= ~halfPhase_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || ctl.clear) begin
         count_q   <= '0;
         expired_q <= 1'b0;
      end else if (tick_q && ctl.run && (!ctl.slow || halfPhase_q)) begin
         if (count_q == `SAFETY_CNT_W'(SAFETY_TICKS - 1)) begin
            expired_q <= 1'b1;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   assign ctl.expired = expired_q;

   chk_clear_zeroes: assert property (@(posedge ref_clk) disable iff (reset)
      ctl.clear |=> (count_q == '0) && !expired_q)
      else $error("timer not cleared");
   chk_slow_hold: assert property (@(posedge ref_clk) disable iff (reset)
      (tick_q && ctl.run && ctl.slow && !halfPhase_q && !ctl.clear)
      |=> $stable(count_q))
      else $error("slow timer advanced on odd tick");
endmodule

// ===== charge_supervisor.sv
/*
 * Charge supervisor top: discharge gate, safety timer control, selector
 * decode, thermistor zones, driver regulator and thermal handling.
 * Assumes comparator and selector inputs synchronous to ref_clk.
 */
// Notes on behaviour
// - Gate on when no valid supply.
// - Gate on in high-impedance mode.
// - Start six hour timer at charge start.
// - Expiry ends charge, opens FET, faults.
// - Fault clears only when charging resumes; code also clears it on entering high-impedance mode.
// - Timer half rate under slowdown conditions.
// - POR, battery swap, selector toggle zero timer.
// - Thermal shutdown zeroes the timer.
// - Driver regulator on with supply, off otherwise; code also turns it off in thermal shutdown.
// - Selector codes: normal, half, 4.06V, suspend.
// - Selector suspend keeps buck running.
// - Hot or cold zone suspends charge, timers.
// - Warm zone lowers regulation 140 mV.
// - Cool zone halves charge current.
// - Thermal regulation folds current to zero.
// - Shutdown temperature stops charge and buck.
// - Restart after cooling below shutdown hysteresis.
// - High-impedance mode shuts down buck.
`timescale 1ns/1ns
`include "charge_supervisor_cfg.svh"
module charge_supervisor #(
   parameter int unsigned TICK_CYCLES  = `TICK_CYCLES,
   parameter int unsigned SAFETY_TICKS = `SAFETY_TICKS,
   parameter bit          TS_PRESENT   = 1'b1,
   parameter bit          FOUR_ZONE    = 1'b1
) (
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // Host selectors and USB limit selects.
   input  wire logic       selector_a,
   input  wire logic       selector_b,
   input  wire logic       usb_limit_sel0,
   input  wire logic       usb_limit_sel1,
   input  wire logic       usb_limit_sel2,
   // Supply and battery comparators.
   input  wire logic       supplyValid,
   input  wire logic       supplyAboveUvlo,
   input  wire logic       supplyAboveSleep,
   input  wire logic       supplyPor,
   input  wire logic       batteryPresent,
   input  wire logic       batteryBelowShort,
   input  wire logic       chargeTerminated,
   // Thermistor comparators, high when beyond each level.
   input  wire logic       beyondHot,
   input  wire logic       beyondWarm,
   input  wire logic       beyondCool,
   input  wire logic       beyondCold,
   // Loop and thermal comparators.
   input  wire logic       loadLimiting,
   input  wire logic       inputCurrentLimiting,
   input  wire logic       inputVoltageLoop,
   input  wire logic       aboveRegThreshold,
   input  wire logic       aboveShutdown,
   input  wire logic       belowRestart,
   input  wire logic       fastCharge,
   // Control outputs.
   output logic            discharge_gate_drive,
   output logic            driver_regulator,
   output logic            buckEnable,
   output logic            chargeEnable,
   output logic            batteryFetOn,
   output logic            timerFault,
   output logic            halfCurrent,
   output logic            lowVreg,
   output logic            warmVregDrop,
   output logic [3:0]      currentFoldStep
);
   import charge_supervisor_pkg::*;

   timer_ctl_if tctl ();

   safety_timer #(
      .TICK_CYCLES  (TICK_CYCLES),
      .SAFETY_TICKS (SAFETY_TICKS)
   ) u_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .ctl     (tctl)
   );

   logic [1:0]  selPrev_q;
   logic        hizPrev_q;
   logic        batPrev_q;
   logic        thermShut_q;
   chg_state_t  state_q;
   chg_state_t  state_d;
   logic [3:0]  fold_q;
   logic [2:0]  foldDiv_q;

   wire logic [1:0] selCode = {selector_a, selector_b};
   wire logic       hiZ = usb_limit_sel0 & usb_limit_sel1 & usb_limit_sel2;
   wire logic       selToggle = (selCode != selPrev_q);
   wire logic       hizToggle = (hiZ != hizPrev_q);
   wire logic       batReinsert = batteryPresent & ~batPrev_q;

   function automatic zone_t zone_of(input logic hot, input logic warm,
                                     input logic cool, input logic cold);
      if (hot || cold) begin
         return ZONE_HALT;
      end else if (warm) begin
         return ZONE_WARM;
      end else if (cool) begin
         return ZONE_COOL;
      end
      return ZONE_NORMAL;
   endfunction

   wire zone_t zone = !TS_PRESENT ? ZONE_NORMAL :
      zone_of(beyondHot, FOUR_ZONE & beyondWarm,
              FOUR_ZONE & beyondCool, beyondCold);

   wire logic selSuspend = (selCode == `SEL_SUSPEND);
   wire logic zoneHalt   = (zone == ZONE_HALT);
   wire logic suspend    = selSuspend | zoneHalt | thermShut_q;
   wire logic restartEvt = supplyPor | batReinsert | selToggle | hizToggle;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         selPrev_q <= 2'h0;
         hizPrev_q <= 1'b0;
         batPrev_q <= 1'b0;
      end else begin
         selPrev_q <= selCode;
         hizPrev_q <= hiZ;
         batPrev_q <= batteryPresent;
      end
   end

   // Shutdown latches until the die has cooled by the hysteresis.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         thermShut_q <= 1'b0;
      end else if (aboveShutdown) begin
         thermShut_q <= 1'b1;
      end else if (belowRestart) begin
         thermShut_q <= 1'b0;
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CHG_IDLE: begin
            if (supplyValid && !hiZ && batteryPresent) begin
               state_d = CHG_RUN;
            end
         end
         CHG_RUN: begin
            if (tctl.expired) begin
               state_d = CHG_FAULT;
            end else if (chargeTerminated) begin
               state_d = CHG_DONE;
            end
         end
         CHG_DONE: begin
            if (restartEvt) begin
               state_d = CHG_IDLE;
            end
         end
         CHG_FAULT: begin
            if (restartEvt) begin
               state_d = CHG_IDLE;
            end
         end
      endcase
      if (!supplyValid || hiZ || thermShut_q) begin
         if (state_q != CHG_FAULT) begin
            state_d = CHG_IDLE;
         end
      end
      if (hiZ || supplyPor || batReinsert) begin
         state_d = CHG_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= CHG_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Timer runs only in CHG_RUN, selector suspend included; a zone halt freezes it, thermal shutdown clears it.
   assign tctl.run = (state_q == CHG_RUN) && !zoneHalt;
   assign tctl.clear = restartEvt || thermShut_q ||
                       (state_q == CHG_IDLE);
   assign tctl.slow = fastCharge && (loadLimiting || inputCurrentLimiting ||
      inputVoltageLoop || aboveRegThreshold || selCode != `SEL_NORMAL ||
      batteryBelowShort || zone == ZONE_WARM || beyondCold);

   // Fold current one step per 8 cycles (80 ns) above the regulation threshold.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         foldDiv_q <= 3'h0;
         fold_q    <= 4'h0;
      end else begin
         foldDiv_q <= foldDiv_q + 3'h1;
         if (foldDiv_q == 3'h0) begin
            if (aboveRegThreshold && fold_q != `FOLD_STEPS) begin
               fold_q <= fold_q + 4'h1;
            end else if (!aboveRegThreshold && fold_q != 4'h0) begin
               fold_q <= fold_q - 4'h1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         discharge_gate_drive <= 1'b1;
         driver_regulator     <= 1'b0;
         buckEnable           <= 1'b0;
      end else begin
         discharge_gate_drive <= !supplyValid || hiZ;
         driver_regulator <= supplyAboveUvlo && supplyAboveSleep &&
                             !thermShut_q;
         // Selector suspend leaves the buck alone.
         buckEnable <= supplyValid && !hiZ && !thermShut_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         chargeEnable    <= 1'b0;
         batteryFetOn    <= 1'b1;
         timerFault      <= 1'b0;
         halfCurrent     <= 1'b0;
         lowVreg         <= 1'b0;
         warmVregDrop    <= 1'b0;
         currentFoldStep <= 4'h0;
      end else begin
         chargeEnable    <= (state_q == CHG_RUN) && !suspend;
         batteryFetOn    <= (state_q != CHG_FAULT);
         timerFault      <= (state_q == CHG_FAULT);
         halfCurrent     <= !suspend && (selCode == `SEL_HALF_CURRENT ||
                            zone == ZONE_COOL);
         lowVreg         <= !suspend && selCode == `SEL_LOW_VREG;
         warmVregDrop    <= !suspend && zone == ZONE_WARM;
         currentFoldStep <= fold_q;
      end
   end

   chk_gate_on: assert property (@(posedge ref_clk) disable iff (reset)
      (!supplyValid || hiZ) |=> discharge_gate_drive)
      else $error("gate off without supply");
   chk_hiz_buck: assert property (@(posedge ref_clk) disable iff (reset)
      hiZ |=> !buckEnable && discharge_gate_drive)
      else $error("buck on in high impedance");
   chk_expiry_fault: assert property (@(posedge ref_clk) disable iff (reset)
      (state_q == CHG_RUN && tctl.expired && !restartEvt && !hiZ &&
       supplyValid && !thermShut_q)
      |=> ##1 timerFault && !batteryFetOn)
      else $error("expiry did not fault");
   chk_fault_hold: assert property (@(posedge ref_clk) disable iff (reset)
      (state_q == CHG_FAULT && !restartEvt && !hiZ && !supplyPor)
      |=> state_q == CHG_FAULT)
      else $error("fault cleared without resume");
   chk_drv_off: assert property (@(posedge ref_clk) disable iff (reset)
      (!supplyAboveUvlo || !supplyAboveSleep || thermShut_q)
      |=> !driver_regulator)
      else $error("driver regulator left on");
   chk_suspend_wins: assert property (@(posedge ref_clk) disable iff (reset)
      selSuspend |=> !chargeEnable && !halfCurrent && !lowVreg)
      else $error("suspend did not win");
   chk_therm_stop: assert property (@(posedge ref_clk) disable iff (reset)
      aboveShutdown |=> ##1 !buckEnable && !chargeEnable)
      else $error("shutdown left buck running");
   chk_fold_limit: assert property (@(posedge ref_clk) disable iff (reset)
      fold_q <= `FOLD_STEPS)
      else $error("fold beyond zero current");
endmodule

// ===== host_thermistor_model.sv
/*
 * Behavioural model of the host GPIOs that drive the charge selector pins,
 * and of the battery pack thermistor seen through its zone comparators.
 * Assumes a shared ref_clk; the testbench calls the tasks hierarchically.
 */
`timescale 1ns/1ns
module host_thermistor_model (
   // Clock.
   input  wire logic ref_clk,
   // Host selector pins.
   output logic      selector_a,
   output logic      selector_b,
   // Thermistor zone comparators.
   output logic      beyondHot,
   output logic      beyondWarm,
   output logic      beyondCool,
   output logic      beyondCold
);
   initial begin
      selector_a = 1'b0;
      selector_b = 1'b0;
      beyondHot  = 1'b0;
      beyondWarm = 1'b0;
      beyondCool = 1'b0;
      beyondCold = 1'b0;
   end

   // A change of code is how the host resumes a faulted charge.
   task automatic set_sel(input logic [1:0] code);
      @(posedge ref_clk);
      selector_a <= code[1];
      selector_b <= code[0];
   endtask

   // The levels nest: a hot pack is also past the warm level, and a cold
   // pack also past the cool level, as a real divider would show.
   task automatic set_zone(input logic [3:0] z);
      @(posedge ref_clk);
      beyondHot  <= z[3];
      beyondWarm <= z[3] | z[2];
      beyondCool <= z[1] | z[0];
      beyondCold <= z[0];
   endtask
endmodule

// ===== tb_top.sv
/*
 * Self-checking testbench for the charge supervisor.
 * Assumes shortened timer counts: 4 cycles per tick, 20 ticks to expiry.
 */
`timescale 1ns/1ns
module tb_top;
   logic       ref_clk, reset, supplyValid, supplyPor, batteryPresent;
   logic       aboveRegThreshold, aboveShutdown, belowRestart;
   logic       uvloOk, sleepOk, chgDone, fastChg;
   logic [3:0] slowCause;
   logic [2:0] usbSel;
   logic       selA, selB, zHot, zWarm, zCool, zCold;
   logic       gate, drv, buck, chgEn, fetOn, fault, halfI, lowV, warmDrop;
   logic [3:0] fold;
   int         bad_count = 0;
   int         n_tests   = 0;

   host_thermistor_model host_thermistor_model_i (.ref_clk(ref_clk),
      .selector_a(selA), .selector_b(selB), .beyondHot(zHot),
      .beyondWarm(zWarm), .beyondCool(zCool), .beyondCold(zCold));

   charge_supervisor #(.TICK_CYCLES(4), .SAFETY_TICKS(20))
      charge_supervisor_i (
      .ref_clk(ref_clk), .reset(reset), .selector_a(selA), .selector_b(selB),
      .usb_limit_sel0(usbSel[0]), .usb_limit_sel1(usbSel[1]),
      .usb_limit_sel2(usbSel[2]), .supplyValid(supplyValid),
      .supplyAboveUvlo(uvloOk), .supplyAboveSleep(sleepOk),
      .supplyPor(supplyPor), .batteryPresent(batteryPresent),
      .batteryBelowShort(slowCause[3]), .chargeTerminated(chgDone),
      .beyondHot(zHot),
      .beyondWarm(zWarm), .beyondCool(zCool), .beyondCold(zCold),
      .loadLimiting(slowCause[0]), .inputCurrentLimiting(slowCause[1]),
      .inputVoltageLoop(slowCause[2]), .aboveRegThreshold(aboveRegThreshold),
      .aboveShutdown(aboveShutdown), .belowRestart(belowRestart),
      .fastCharge(fastChg), .discharge_gate_drive(gate), .driver_regulator(drv),
      .buckEnable(buck), .chargeEnable(chgEn), .batteryFetOn(fetOn),
      .timerFault(fault), .halfCurrent(halfI), .lowVreg(lowV),
      .warmVregDrop(warmDrop), .currentFoldStep(fold));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic check_bit(input logic got, input logic exp, input string s);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, s);
      end
   endtask

   task automatic check_fold(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: fold step %0d", $time, got);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Expiry must come neither before lo cycles nor at or after hi cycles.
   task automatic wait_fault(input int lo, input int hi);
      int n;
      n = 0;
      while (fault !== 1'b1 && n < hi) begin
         step(1);
         n++;
      end
      if (n >= hi) begin
         bad_count++;
         $display("unexpected at %0t: no timer expiry", $time);
         final_report();
      end else begin
         check_bit(n >= lo, 1'b1, "timer expired early");
      end
   endtask

   task automatic toggle_sel;
      host_thermistor_model_i.set_sel(2'h3);
      host_thermistor_model_i.set_sel(2'h0);
      step(3);
   endtask

   initial begin
      reset = 1'b1;
      supplyValid = 1'b0;
      supplyPor = 1'b0;
      batteryPresent = 1'b0;
      slowCause = 4'h0;
      uvloOk = 1'b0;
      sleepOk = 1'b0;
      chgDone = 1'b0;
      fastChg = 1'b1;
      aboveRegThreshold = 1'b0;
      aboveShutdown = 1'b0;
      belowRestart = 1'b0;
      usbSel = 3'h0;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      step(1);
      check_bit(gate, 1'b1, "gate at reset");
      check_bit(fetOn, 1'b1, "fet at reset");
      check_bit(fault, 1'b0, "fault at reset");
      $display("test reset done");

      @(posedge ref_clk);
      supplyValid <= 1'b1;
      uvloOk <= 1'b1;
      sleepOk <= 1'b1;
      batteryPresent <= 1'b1;
      step(3);
      check_bit(gate, 1'b0, "gate with supply");
      check_bit(drv, 1'b1, "regulator with supply");
      check_bit(chgEn, 1'b1, "charge start");
      wait_fault(70, 120);
      step(1);
      check_bit(fetOn, 1'b0, "fet after expiry");
      check_bit(chgEn, 1'b0, "charge after expiry");
      @(posedge ref_clk);
      supplyValid <= 1'b0;
      uvloOk <= 1'b0;
      sleepOk <= 1'b0;
      step(2);
      check_bit(gate, 1'b1, "gate without supply");
      check_bit(drv, 1'b0, "regulator without supply");
      check_bit(fault, 1'b1, "fault kept");
      @(posedge ref_clk);
      supplyValid <= 1'b1;
      uvloOk <= 1'b1;
      sleepOk <= 1'b1;
      toggle_sel();
      check_bit(fault, 1'b0, "fault after toggle");
      check_bit(chgEn, 1'b1, "charge resumed");
      $display("test expiry done");

      // Load, input current, input voltage and short-battery slowdowns in turn, then one with fast charge off.
      for (int k = 0; k < 5; k++) begin
         @(posedge ref_clk);
         slowCause <= 4'h1 << k[1:0];
         fastChg <= (k < 4);
         if (k < 4) begin
            wait_fault(140, 220);
         end else begin
            wait_fault(70, 120);
         end
         @(posedge ref_clk);
         slowCause <= 4'h0;
         fastChg <= 1'b1;
         supplyPor <= 1'b1;
         @(posedge ref_clk);
         supplyPor <= 1'b0;
         step(3);
         check_bit(fault, 1'b0, "fault after restart");
      end
      @(posedge ref_clk);
      uvloOk <= 1'b0;
      step(2);
      check_bit(drv, 1'b0, "regulator below lockout");
      @(posedge ref_clk);
      uvloOk <= 1'b1;
      sleepOk <= 1'b0;
      step(2);
      check_bit(drv, 1'b0, "regulator in sleep margin");
      @(posedge ref_clk);
      sleepOk <= 1'b1;
      $display("test slow timer done");

      step(53);
      @(posedge ref_clk);
      aboveShutdown <= 1'b1;
      step(2);
      check_bit(buck, 1'b0, "buck in shutdown");
      check_bit(chgEn, 1'b0, "charge in shutdown");
      check_bit(drv, 1'b0, "regulator in shutdown");
      @(posedge ref_clk);
      aboveShutdown <= 1'b0;
      belowRestart <= 1'b1;
      step(3);
      check_bit(chgEn, 1'b1, "charge after cooling");
      @(posedge ref_clk);
      belowRestart <= 1'b0;
      wait_fault(70, 120);
      @(posedge ref_clk);
      usbSel <= 3'h7;
      step(2);
      check_bit(gate, 1'b1, "gate in hi-z");
      check_bit(buck, 1'b0, "buck in hi-z");
      @(posedge ref_clk);
      usbSel <= 3'h0;
      step(3);
      check_bit(fault, 1'b0, "fault after hi-z");
      $display("test thermal done");

      // A terminated charge must never run into a timer fault.
      @(posedge ref_clk);
      chgDone <= 1'b1;
      step(2);
      check_bit(chgEn, 1'b0, "charge after termination");
      step(100);
      check_bit(fault, 1'b0, "fault after termination");
      @(posedge ref_clk);
      chgDone <= 1'b0;
      $display("test termination done");

      for (int c = 1; c < 4; c++) begin
         host_thermistor_model_i.set_sel(c[1:0]);
         step(3);
         check_bit(halfI, c == 1, "half current code");
         check_bit(lowV, c == 2, "low vreg code");
         check_bit(chgEn, c != 3, "suspend code");
         check_bit(buck, 1'b1, "buck with selector");
      end
      host_thermistor_model_i.set_sel(2'h1);
      host_thermistor_model_i.set_zone(4'h4);
      step(3);
      check_bit(warmDrop, 1'b1, "warm drop");
      check_bit(halfI, 1'b1, "warm and half");
      host_thermistor_model_i.set_sel(2'h0);
      host_thermistor_model_i.set_zone(4'h2);
      step(3);
      check_bit(halfI, 1'b1, "cool half");
      check_bit(warmDrop, 1'b0, "cool no drop");
      host_thermistor_model_i.set_zone(4'h8);
      step(3);
      check_bit(chgEn, 1'b0, "hot suspend");
      host_thermistor_model_i.set_zone(4'h1);
      step(3);
      check_bit(chgEn, 1'b0, "cold suspend");
      host_thermistor_model_i.set_zone(4'h0);
      $display("test selector and zones done");

      toggle_sel();
      @(posedge ref_clk);
      aboveRegThreshold <= 1'b1;
      step(88);
      check_fold(fold, 4'hA);
      @(posedge ref_clk);
      aboveRegThreshold <= 1'b0;
      step(88);
      check_fold(fold, 4'h0);
      $display("test fold done");
      final_report();
   end
endmodule
